// ===== rtl/buck_output_dvs_control.sv
// Purpose: enable sequencing, soft-start, range and setpoint control of four bucks
// Assumes: register port is the byte side of the serial register interface
// Notes: analog loop is outside; this block drives codes and control levels
`timescale 1ns/1ps
module buck_output_dvs_control #(
    parameter int CYC_PER_US = 250
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input buck_dvs_pkg::reg_req_t reg_req,
    output logic [7:0] rd_data,
    // pins and analog status
    input wire logic external_enable_pin,
    input wire logic vin_window_fault,
    input wire logic [3:0] fault_restart,
    input wire logic [3:0] power_good_flag,
    input wire logic [3:0] overvoltage_flag,
    input wire logic [3:0] current_limit_flag,
    // converter control
    output buck_dvs_pkg::conv_out_t [3:0] conv_out,
    output logic [3:0] pg_masked,
    output logic [3:0] ov_masked,
    output logic [3:0] current_limit_flag_masked,
    output logic scaling_active,
    output logic main_reset_out_n
);
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] gctl_r;
    logic [2:0] range_r;
    logic [7:0] ctrl_r [4];
    logic [7:0] prim_r [4];
    logic [7:0] sec_r [4];
    logic [1:0] slew_r;
    logic [3:0] en_r;
    logic [3:0] en_prev_r;
    logic [3:0] ss_busy;
    logic [3:0] ss_start;
    logic [3:0] range_high;
    logic [7:0] code_r [4];
    logic [7:0] target [4];
    logic [23:0] ss_cnt_r [4];
    logic scaling_r;
    logic transition;
    logic wr_sel;
    buck_dvs_pkg::seq_state_t seq_r;
    logic [1:0] seq_idx_r;

    assign wr_sel = reg_req.wr;
    // fourth converter has no range bit
    assign range_high = {1'b1, range_r};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gctl_r <= buck_dvs_pkg::GLOBAL_CONTROL_RST;
            range_r <= {3{buck_dvs_pkg::RANGE_RST[buck_dvs_pkg::RANGE_BIT]}};
            slew_r <= buck_dvs_pkg::SLEW_RST;
        end
        else if (wr_sel)
        begin
            // range writes to a live converter are dropped
            case (reg_req.addr)
                buck_dvs_pkg::GLOBAL_CONTROL_ADDR: gctl_r <= reg_req.wdata;
                buck_dvs_pkg::RANGE_ONE_ADDR: if (!en_r[0]) range_r[0] <= reg_req.wdata[0];
                buck_dvs_pkg::RANGE_TWO_ADDR: if (!en_r[1]) range_r[1] <= reg_req.wdata[0];
                buck_dvs_pkg::RANGE_THREE_ADDR: if (!en_r[2]) range_r[2] <= reg_req.wdata[0];
                buck_dvs_pkg::SLEW_ADDR: slew_r <= reg_req.wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rd_data <= 8'h00;
        else if (reg_req.rd)
        begin
            // unmapped addresses read zero
            rd_data <= 8'h00;
            case (reg_req.addr)
                buck_dvs_pkg::GLOBAL_CONTROL_ADDR: rd_data <= gctl_r;
                buck_dvs_pkg::RANGE_ONE_ADDR: rd_data <= {7'h00, range_r[0]};
                buck_dvs_pkg::RANGE_TWO_ADDR: rd_data <= {7'h00, range_r[1]};
                buck_dvs_pkg::RANGE_THREE_ADDR: rd_data <= {7'h00, range_r[2]};
                buck_dvs_pkg::SLEW_ADDR: rd_data <= {6'h00, slew_r};
                buck_dvs_pkg::STATUS_ADDR: rd_data <= {ss_busy, en_r};
                default:
                begin
                    for (int k = 0; k < buck_dvs_pkg::NCONV; k++)
                    begin
                        if (reg_req.addr == buck_dvs_pkg::CONV_CTRL_BASE + 8'(k))
                            rd_data <= ctrl_r[k];
                        if (reg_req.addr == buck_dvs_pkg::PRIMARY_BASE + 8'(k))
                            rd_data <= prim_r[k];
                        if (reg_req.addr == buck_dvs_pkg::SECONDARY_BASE + 8'(k))
                            rd_data <= sec_r[k];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // power-up sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            seq_r <= buck_dvs_pkg::SEQ_START;
            seq_idx_r <= 2'h0;
        end
        else
        begin
            case (seq_r)
                buck_dvs_pkg::SEQ_START: seq_r <= buck_dvs_pkg::SEQ_WAIT;
                buck_dvs_pkg::SEQ_WAIT:
                    // next rail only after this one finished its ramp
                    if (en_prev_r[seq_idx_r] && !ss_busy[seq_idx_r])
                    begin
                        if (seq_idx_r == 2'(buck_dvs_pkg::LAST_CONV))
                            seq_r <= buck_dvs_pkg::SEQ_ACTIVE;
                        else
                        begin
                            seq_idx_r <= seq_idx_r + 2'h1;
                            seq_r <= buck_dvs_pkg::SEQ_START;
                        end
                    end
                buck_dvs_pkg::SEQ_ACTIVE: seq_r <= buck_dvs_pkg::SEQ_ACTIVE;
                default: seq_r <= buck_dvs_pkg::SEQ_START;
            endcase
        end
    end

    // ------------------------------------------------------------
    // scaling entry and shared slew tick
    // ------------------------------------------------------------
    logic [15:0] slew_cnt_r;
    logic slew_tick;
    logic [15:0] slew_period;
    assign slew_period = 16'(buck_dvs_pkg::SLEW_STEP_NS[slew_r] / buck_dvs_pkg::CLK_PERIOD_NS);
    assign slew_tick = (slew_cnt_r >= slew_period - 16'h1);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            scaling_r <= 1'b0;
        else
            scaling_r <= gctl_r[buck_dvs_pkg::SCALING_BIT] & external_enable_pin;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || slew_tick)
            slew_cnt_r <= 16'h0;
        else
            slew_cnt_r <= slew_cnt_r + 16'h1;
    end

    // ------------------------------------------------------------
    // per-converter control
    // ------------------------------------------------------------
    function automatic logic [23:0] ss_cycles(input int conv, input logic [2:0] code,
                                              input logic low);
        int us;
        int c;
        us = (conv == buck_dvs_pkg::LAST_CONV) ? buck_dvs_pkg::SS_US_LAST[code]
                                               : buck_dvs_pkg::SS_US_MAIN[code];
        c = us * CYC_PER_US;
        if (low)
            c = (c * buck_dvs_pkg::LOW_SS_NUM) / buck_dvs_pkg::LOW_SS_DEN;
        return 24'(c);
    endfunction : ss_cycles

    for (genvar i = 0; i < buck_dvs_pkg::NCONV; i++)
    begin : g_conv
        logic [7:0] ramp_gap;
        logic [21:0] vout_uv;
        assign ss_busy[i] = (ss_cnt_r[i] != 24'h0);
        assign ss_start[i] = en_r[i] & (~en_prev_r[i] | fault_restart[i]);
        assign target[i] = scaling_r ? sec_r[i] : prim_r[i];
        assign vout_uv = range_high[i]
            ? buck_dvs_pkg::HIGH_BASE_UV + 22'(code_r[i]) * buck_dvs_pkg::HIGH_STEP_UV
            : buck_dvs_pkg::LOW_BASE_UV + 22'(code_r[i]) * buck_dvs_pkg::LOW_STEP_UV;
        assign ramp_gap = code_r[i] - target[i];

        always_ff @(posedge sys_clk)
        begin
            if (rst)
            begin
                ctrl_r[i] <= buck_dvs_pkg::CTRL_RST;
                prim_r[i] <= buck_dvs_pkg::PRIMARY_RST;
                sec_r[i] <= buck_dvs_pkg::SECONDARY_RST;
            end
            else if (wr_sel)
            begin
                if (reg_req.addr == buck_dvs_pkg::CONV_CTRL_BASE + 8'(i))
                    ctrl_r[i] <= reg_req.wdata;
                if (reg_req.addr == buck_dvs_pkg::PRIMARY_BASE + 8'(i))
                    prim_r[i] <= reg_req.wdata;
                if (reg_req.addr == buck_dvs_pkg::SECONDARY_BASE + 8'(i))
                    sec_r[i] <= reg_req.wdata;
            end
        end

        always_ff @(posedge sys_clk)
        begin
            if (rst)
            begin
                en_r[i] <= 1'b0;
                en_prev_r[i] <= 1'b0;
            end
            else
            begin
                en_prev_r[i] <= en_r[i];
                if (seq_r == buck_dvs_pkg::SEQ_ACTIVE)
                    en_r[i] <= ~ctrl_r[i][buck_dvs_pkg::OFF_BIT];
                else if (seq_r == buck_dvs_pkg::SEQ_START && seq_idx_r == 2'(i))
                    en_r[i] <= 1'b1;
            end
        end

        always_ff @(posedge sys_clk)
        begin
            if (rst || !en_r[i])
                ss_cnt_r[i] <= 24'h0;
            else if (ss_start[i])
                ss_cnt_r[i] <= ss_cycles(i, ctrl_r[i][buck_dvs_pkg::RAMP_LSB +: 3],
                                         ~range_high[i]);
            else if (ss_busy[i])
                ss_cnt_r[i] <= ss_cnt_r[i] - 24'h1;
        end

        // soft-start owns the ramp; slew applies only to setpoint moves
        always_ff @(posedge sys_clk)
        begin
            if (rst)
                code_r[i] <= buck_dvs_pkg::PRIMARY_RST;
            else if (!en_r[i] || ss_start[i] || ss_busy[i])
                code_r[i] <= target[i];
            else if (slew_tick && ramp_gap != 8'h00)
                code_r[i] <= (code_r[i] > target[i]) ? code_r[i] - 8'h01
                                                     : code_r[i] + 8'h01;
        end

        always_ff @(posedge sys_clk)
        begin
            if (rst)
                conv_out[i] <= '0;
            else
            begin
                conv_out[i].enabled <= en_r[i];
                conv_out[i].discharge <= ~en_r[i] & ctrl_r[i][buck_dvs_pkg::DIS_BIT];
                conv_out[i].soft_start <= ss_busy[i];
                conv_out[i].range_high <= range_high[i];
                conv_out[i].code <= code_r[i];
                conv_out[i].vout_uv <= vout_uv;
            end
        end
    end

    // ------------------------------------------------------------
    // flag suppression and main reset
    // ------------------------------------------------------------
    logic [3:0] moving;
    logic [3:0] pg_eff;
    for (genvar j = 0; j < buck_dvs_pkg::NCONV; j++)
    begin : g_move
        assign moving[j] = en_r[j] & ~ss_busy[j] & (code_r[j] != target[j]);
    end
    assign transition = |moving;
    assign pg_eff = power_good_flag | {4{transition}};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pg_masked <= 4'h0;
            ov_masked <= 4'h0;
            current_limit_flag_masked <= 4'h0;
            main_reset_out_n <= 1'b0;
            scaling_active <= 1'b0;
        end
        else
        begin
            pg_masked <= pg_eff;
            ov_masked <= overvoltage_flag & ~{4{transition}};
            current_limit_flag_masked <= current_limit_flag & ~{4{transition}};
            // no release delay modelled here, only the immediate assert
            main_reset_out_n <= ~(vin_window_fault | |(en_r & ~pg_eff));
            scaling_active <= scaling_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_off_write;
        reg_req.wr && reg_req.addr == buck_dvs_pkg::CONV_CTRL_BASE
        && reg_req.wdata[buck_dvs_pkg::OFF_BIT] && seq_r == buck_dvs_pkg::SEQ_ACTIVE;
    endsequence
    sequence s_fault_kick;
        en_r[2] && en_prev_r[2] && fault_restart[2];
    endsequence

    seq_order_a: assert property ($rose(en_r[1]) |-> en_r[0] && !ss_busy[0])
        else $error("rail two enabled before rail one settled");
    disable_one_a: assert property (s_off_write ##1 1 |=> !en_r[0]
        && en_r[3:1] == $past(en_r[3:1])) else $error("single disable failed");
    discharge_off_a: assert property (conv_out[0].discharge |-> !conv_out[0].enabled)
        else $error("discharge while enabled");
    fault_restart_a: assert property (s_fault_kick |=> ss_busy[2] ##1 ss_busy[2])
        else $error("no soft-start after fault");
    ss_main_a: assert property (ss_start[1] && range_high[1]
        |=> ss_cnt_r[1] == 24'(buck_dvs_pkg::SS_US_MAIN[$past(ctrl_r[1][4:2])] * CYC_PER_US))
        else $error("wrong soft-start count, main rails");
    ss_last_a: assert property (ss_start[3]
        |=> ss_cnt_r[3] == 24'(buck_dvs_pkg::SS_US_LAST[$past(ctrl_r[3][4:2])] * CYC_PER_US))
        else $error("wrong soft-start count, fourth rail");
    ss_low_a: assert property (ss_start[0] && !range_high[0]
        |=> ss_cnt_r[0] == 24'((buck_dvs_pkg::SS_US_MAIN[$past(ctrl_r[0][4:2])] * CYC_PER_US
            * 3) / 4)) else $error("low range soft-start not scaled");
    // output flops still hold their reset zeros on the first edge after release
    vout_map_a: assert property (!$past(rst)
        |-> conv_out[2].vout_uv == (conv_out[2].range_high
        ? 22'd800000 + 22'(conv_out[2].code) * 22'd12500
        : 22'd600000 + 22'(conv_out[2].code) * 22'd9375)) else $error("vout mapping wrong");
    scaling_entry_a: assert property (gctl_r[1] && external_enable_pin
        |=> scaling_r ##1 scaling_active) else $error("scaling not entered");
    slew_step_a: assert property ($past(en_r[0] && !ss_busy[0] && !ss_start[0])
        && en_r[0] |-> code_r[0] == $past(code_r[0]) || code_r[0] == $past(code_r[0]) + 8'h01
        || code_r[0] == $past(code_r[0]) - 8'h01) else $error("setpoint jumped");
    flag_mask_a: assert property (transition && !vin_window_fault |=> main_reset_out_n
        && ov_masked == 4'h0) else $error("flags leaked during transition");
    vin_reset_a: assert property (vin_window_fault |=> !main_reset_out_n)
        else $error("main reset not asserted");
endmodule : buck_output_dvs_control

// ===== rtl/buck_dvs_pkg.sv
// Purpose: constants and types shared by the buck converter control block
// Assumes: 250 MHz sys_clk, byte-wide register port
// Notes: soft-start tables are in microseconds, slew steps in nanoseconds
package buck_dvs_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] GLOBAL_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] RANGE_TWO_ADDR = 8'h72;
    localparam logic [7:0] RANGE_ONE_ADDR = 8'h74;
    localparam logic [7:0] RANGE_THREE_ADDR = 8'h89;
    localparam logic [7:0] CONV_CTRL_BASE = 8'h10;
    localparam logic [7:0] PRIMARY_BASE = 8'h20;
    localparam logic [7:0] SECONDARY_BASE = 8'h28;
    localparam logic [7:0] SLEW_ADDR = 8'h30;
    localparam logic [7:0] STATUS_ADDR = 8'h38;
    localparam int SCALING_BIT = 1;
    localparam int RANGE_BIT = 0;
    localparam int OFF_BIT = 0;
    localparam int DIS_BIT = 1;
    localparam int RAMP_LSB = 2;
    localparam logic [7:0] GLOBAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] RANGE_RST = 8'h01;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PRIMARY_RST = 8'h50;
    localparam logic [7:0] SECONDARY_RST = 8'h40;
    localparam logic [1:0] SLEW_RST = 2'h0;
    // ------------------------------------------------------------
    // timing and voltage constants
    // ------------------------------------------------------------
    localparam int NCONV = 4;
    localparam int LAST_CONV = 3;
    localparam int SS_US_MAIN [8] = '{150, 200, 250, 300, 350, 395, 440, 485};
    localparam int SS_US_LAST [8] = '{25, 51, 76, 102, 127, 153, 178, 204};
    localparam int LOW_SS_NUM = 3;
    localparam int LOW_SS_DEN = 4;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SLEW_STEP_NS [4] = '{1000, 500, 250, 125};
    localparam logic [21:0] LOW_BASE_UV = 22'h0927C0;
    localparam logic [21:0] LOW_STEP_UV = 22'h00249F;
    localparam logic [21:0] HIGH_BASE_UV = 22'h0C3500;
    localparam logic [21:0] HIGH_STEP_UV = 22'h0030D4;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic enabled;
        logic discharge;
        logic soft_start;
        logic range_high;
        logic [7:0] code;
        logic [21:0] vout_uv;
    } conv_out_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef enum logic [1:0] {
        SEQ_START = 2'b00,
        SEQ_WAIT = 2'b01,
        SEQ_ACTIVE = 2'b10
    } seq_state_t;
endpackage : buck_dvs_pkg

// ===== tb/buck_host_model.sv
// Purpose: host side of the byte register port
// Assumes: one-cycle strobes, read data the cycle after rd
// Notes: released fields show inverted data so stale values cannot pass
`timescale 1ns/1ps
module buck_host_model (
    // clock
    input wire logic sys_clk,
    // register port
    input wire logic [7:0] rd_data,
    output buck_dvs_pkg::reg_req_t reg_req
);
    initial reg_req = '0;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        @(posedge sys_clk);
        d = rd_data;
    endtask : read_reg
endmodule : buck_host_model

// ===== tb/test_buck_output_dvs_control.sv
// Purpose: self-checking bench of the buck control block
// Assumes: CYC_PER_US shortened to 2 so soft-start runs stay short
// Notes: soft-start and slew counts allow a small flop-delay tolerance
`timescale 1ns/1ps
module test_buck_output_dvs_control;
    localparam int CYC = 2;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic external_enable_pin = 1'b0;
    logic vin_window_fault = 1'b0;
    logic [3:0] fault_restart = 4'h0;
    logic [3:0] power_good_flag = 4'hF;
    logic [3:0] overvoltage_flag = 4'h0;
    logic [3:0] current_limit_flag = 4'h0;
    buck_dvs_pkg::reg_req_t reg_req;
    logic [7:0] rd_data;
    buck_dvs_pkg::conv_out_t [3:0] conv_out;
    logic [3:0] pg_masked;
    logic [3:0] ov_masked;
    logic [3:0] current_limit_flag_masked;
    logic scaling_active;
    logic main_reset_out_n;
    int num_errors = 0;
    int tests_run = 0;
    logic [31:0] rnd = 32'hA048D8BA;
    always #2 sys_clk = ~sys_clk;
    buck_output_dvs_control #(.CYC_PER_US(CYC)) dut (
        .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
        .external_enable_pin(external_enable_pin),
        .vin_window_fault(vin_window_fault), .fault_restart(fault_restart),
        .power_good_flag(power_good_flag), .overvoltage_flag(overvoltage_flag),
        .current_limit_flag(current_limit_flag), .conv_out(conv_out),
        .pg_masked(pg_masked), .ov_masked(ov_masked), .current_limit_flag_masked(current_limit_flag_masked),
        .scaling_active(scaling_active), .main_reset_out_n(main_reset_out_n)
    );
    buck_host_model host (.sys_clk(sys_clk), .rd_data(rd_data), .reg_req(reg_req));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_cnt(input int got, input int exp, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol)
        begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_cnt
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int ss_exp(input int i, input int c, input bit low);
        int us;
        us = (i == 3) ? buck_dvs_pkg::SS_US_LAST[c] : buck_dvs_pkg::SS_US_MAIN[c];
        return low ? us * CYC * 3 / 4 : us * CYC;
    endfunction : ss_exp
    function automatic logic [7:0] range_addr(input int i);
        return (i == 0) ? 8'h74 : (i == 1) ? 8'h72 : 8'h89;
    endfunction : range_addr
    // length of the next soft-start window of converter i
    task automatic ss_len(input int i, input bit nxt, output int n);
        int w;
        w = 0;
        n = 0;
        while (conv_out[i].soft_start !== 1'b1 && w < 60)
        begin
            tick();
            w++;
        end
        check_bit(conv_out[i].enabled, 1'b1);
        if (nxt)
            check_bit(conv_out[i + 1].enabled, 1'b0);
        while (conv_out[i].soft_start === 1'b1 && n < 2000)
        begin
            tick();
            n++;
        end
    endtask : ss_len
    task automatic wait_code(input int i, input logic [7:0] c, output int n);
        n = 0;
        while (conv_out[i].code !== c && n < 3000)
        begin
            tick();
            n++;
        end
    endtask : wait_code
    // disable, reprogram while off, re-enable and check the ramp
    task automatic ss_test(input int i, input int c, input bit low,
                           input logic [7:0] pc, input bit dis);
        int n;
        logic [21:0] uv;
        logic [7:0] ca;
        ca = buck_dvs_pkg::CONV_CTRL_BASE + 8'(i);
        host.write_reg(ca, dis ? 8'h03 : 8'h01);
        repeat (4) tick();
        check_bit(conv_out[i].enabled, 1'b0);
        check_bit(conv_out[(i + 1) % 4].enabled, 1'b1);
        check_bit(conv_out[i].discharge, dis);
        if (i < 3)
            host.write_reg(range_addr(i), {7'h00, ~low});
        host.write_reg(buck_dvs_pkg::PRIMARY_BASE + 8'(i), pc);
        host.write_reg(ca, {3'h0, 3'(c), 2'h0});
        ss_len(i, 1'b0, n);
        check_cnt(n, ss_exp(i, c, low), 1);
        if (low)
            uv = 22'(32'h000927C0 + 32'h0000249F * pc);
        else
            uv = 22'(32'h000C3500 + 32'h000030D4 * pc);
        check_bit(conv_out[i].range_high, ~low);
        check_val(24'(conv_out[i].code), 24'(pc));
        check_val(24'(conv_out[i].vout_uv), 24'(uv));
    endtask : ss_test
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    logic [7:0] ra [11] = '{8'h00, 8'h74, 8'h72, 8'h89, 8'h20, 8'h23, 8'h28,
                            8'h2B, 8'h10, 8'hFE, 8'h38};
    logic [7:0] re [11] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h50, 8'h50, 8'h40,
                            8'h40, 8'h00, 8'h00, 8'h0F};
    initial
    begin
        int n;
        int d;
        logic [7:0] v;
        logic [7:0] p;
        repeat (8) tick();
        check_bit(conv_out === '0, 1'b1);
        check_bit(main_reset_out_n, 1'b0);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            ss_len(i, i < 3, n);
            check_cnt(n, ss_exp(i, 0, 0), 1);
        end
        $display("test power_up done");
        host.write_reg(8'hFE, 8'h5A);
        host.write_reg(8'h74, 8'h00);
        for (int k = 0; k < 11; k++)
        begin
            host.read_reg(ra[k], v);
            check_val(24'(v), 24'(re[k]));
        end
        $display("test registers done");
        for (int c = 0; c < 8; c++)
        begin
            rnd = lfsr(rnd);
            ss_test(0, c, 1'b1, rnd[7:0], c[0]);
            ss_test(3, c, 1'b0, rnd[15:8], ~c[0]);
        end
        ss_test(2, 5, 1'b0, rnd[23:16], 1'b1);
        @(posedge sys_clk);
        fault_restart <= 4'h4;
        @(posedge sys_clk);
        fault_restart <= 4'h0;
        ss_len(2, 1'b0, n);
        check_cnt(n, ss_exp(2, 5, 0), 1);
        $display("test soft_start done");
        rnd = lfsr(rnd);
        p = {1'b1, rnd[6:0]};
        d = 4 + int'(rnd[13:11]);
        ss_test(1, int'(rnd[10:8]), 1'b0, p, 1'b0);
        host.write_reg(buck_dvs_pkg::SECONDARY_BASE + 8'h01, p - 8'(d));
        host.write_reg(buck_dvs_pkg::SLEW_ADDR, 8'h03);
        @(posedge sys_clk);
        external_enable_pin <= 1'b1;
        repeat (4) tick();
        check_bit(scaling_active, 1'b0);
        host.write_reg(buck_dvs_pkg::GLOBAL_CONTROL_ADDR, 8'h02);
        repeat (3) tick();
        check_bit(scaling_active, 1'b1);
        // slew tick runs free, so time the move from its first step
        wait_code(1, p - 8'h01, n);
        power_good_flag <= 4'hD;
        overvoltage_flag <= 4'h2;
        current_limit_flag <= 4'h2;
        repeat (2) tick();
        check_bit(pg_masked[1], 1'b1);
        check_bit(ov_masked[1] | current_limit_flag_masked[1], 1'b0);
        check_bit(main_reset_out_n, 1'b1);
        wait_code(1, p - 8'(d), n);
        check_cnt(n + 2, (d - 1) * 125 / 4, d + 10);
        power_good_flag <= 4'hF;
        overvoltage_flag <= 4'h0;
        current_limit_flag <= 4'h0;
        external_enable_pin <= 1'b0;
        wait_code(1, p, n);
        check_cnt(n, d * 125 / 4, d + 10);
        $display("test scaling done");
        repeat (4) tick();
        check_bit(main_reset_out_n, 1'b1);
        vin_window_fault <= 1'b1;
        repeat (2) tick();
        check_bit(main_reset_out_n, 1'b0);
        vin_window_fault <= 1'b0;
        host.write_reg(buck_dvs_pkg::CONV_CTRL_BASE + 8'h02, 8'h01);
        power_good_flag <= 4'hB;
        repeat (4) tick();
        check_bit(main_reset_out_n, 1'b1);
        power_good_flag <= 4'hA;
        repeat (2) tick();
        check_bit(main_reset_out_n, 1'b0);
        $display("test main_reset done");
        end_of_test();
    end
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end
endmodule : test_buck_output_dvs_control
